// ==== hdl/byte_alu_map.svh ====
`ifndef BYTE_ALU_MAP_SVH
`define BYTE_ALU_MAP_SVH

// ----------------------------------------------------------------
// Instruction word layout
// ----------------------------------------------------------------
`define INSN_W          14
`define DATA_W          8
`define FADDR_W         7
`define OPC_HI_MSB      13
`define OPC_HI_LSB      12
`define OPC_LO_MSB      11
`define OPC_LO_LSB      8
`define DEST_BIT        7
`define FADDR_MSB       6
`define LIT_MSB         7

// ----------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------
`define OPC_HI_REG      2'h0
`define OPC_HI_LIT      2'h3
`define OPC_ADD_WF      4'h7
`define OPC_AND_WF      4'h5
`define OPC_AND_LW      4'h9

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WORK_RST        8'h00
`define ZERO_RST        1'h0

`endif

// ==== hdl/byte_alu_pkg.sv ====
package byte_alu_pkg;

  typedef enum logic [3:0] {
    OP_NONE          = 4'h1,
    OP_ADD_WORK_FILE = 4'h2,
    OP_AND_LIT_WORK  = 4'h4,
    OP_AND_WORK_FILE = 4'h8
  } alu_op_t;

  typedef enum logic [3:0] {
    PH_DECODE  = 4'h1,
    PH_READ    = 4'h2,
    PH_PROCESS = 4'h4,
    PH_WRITE   = 4'h8
  } phase_t;

  typedef struct packed {
    logic       wr_en;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_t;

  typedef struct packed {
    alu_op_t    op;
    logic       dest_file;
    logic [6:0] addr;
    logic [7:0] literal;
  } decoded_t;

endpackage

// ==== hdl/byte_alu_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "byte_alu_map.svh"

module byte_alu_decode (
  input  wire logic [13:0]           i_insn,
  output byte_alu_pkg::decoded_t     o_dec
);
  import byte_alu_pkg::*;

  logic [1:0] opc_hi;
  logic [3:0] opc_lo;

  assign opc_hi = i_insn[`OPC_HI_MSB:`OPC_HI_LSB];
  assign opc_lo = i_insn[`OPC_LO_MSB:`OPC_LO_LSB];

  // ----------------------------------------------------------------
  // Field split
  // ----------------------------------------------------------------
  always_comb begin
    o_dec.addr      = i_insn[`FADDR_MSB:0];
    o_dec.dest_file = i_insn[`DEST_BIT];
    o_dec.literal   = i_insn[`LIT_MSB:0];
    o_dec.op        = OP_NONE;
    if (opc_hi == `OPC_HI_REG && opc_lo == `OPC_ADD_WF) begin
      o_dec.op = OP_ADD_WORK_FILE;
    end else if (opc_hi == `OPC_HI_REG && opc_lo == `OPC_AND_WF) begin
      o_dec.op = OP_AND_WORK_FILE;
    end else if (opc_hi == `OPC_HI_LIT && opc_lo == `OPC_AND_LW) begin
      o_dec.op = OP_AND_LIT_WORK;
    end
  end

endmodule // byte_alu_decode

`default_nettype wire

// ==== hdl/byte_alu_add_and_ops.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "byte_alu_map.svh"

module byte_alu_add_and_ops (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_insn_valid,
  input  wire logic [13:0]            i_insn,
  input  wire logic [7:0]             i_file_rdata,
  output logic                        o_busy,
  output logic                        o_file_rd_en,
  output logic [6:0]                  o_file_raddr,
  output byte_alu_pkg::file_wr_t      o_file_wr,
  output logic [7:0]                  o_work,
  output logic                        o_zero_wr_en,
  output logic                        o_zero,
  output logic                        o_done
);
  import byte_alu_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  phase_t     phase_reg;
  decoded_t   dec_now;
  decoded_t   dec_reg;
  logic [7:0] operand_reg;
  logic [7:0] result_reg;
  logic [7:0] work_reg;
  logic       zero_reg;
  logic       zero_we_reg;
  logic       done_reg;
  file_wr_t   file_wr_reg;
  logic [7:0] result_next;
  logic [8:0] sum_wide;
  logic [8:0] any_set;
  logic       result_is_zero;
  logic       lit_form;
  logic       reg_form;
  logic       and_form;
  logic       in_write;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  byte_alu_decode u_decode (
    .i_insn (i_insn),
    .o_dec  (dec_now)
  );

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  // New instruction only taken in decode phase; one instruction cycle each
  // Valid seen while busy is dropped, not queued; the caller must hold it
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_reg <= PH_DECODE;
    end else begin
      unique case (phase_reg)
        PH_DECODE: begin
          if (i_insn_valid) begin
            phase_reg <= PH_READ;
          end
        end
        PH_READ: begin
          phase_reg <= PH_PROCESS;
        end
        PH_PROCESS: begin
          phase_reg <= PH_WRITE;
        end
        PH_WRITE: begin
          phase_reg <= PH_DECODE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dec_reg <= '{op: OP_NONE, dest_file: 1'b0, addr: 7'h00, literal: 8'h00};
    end else if (phase_reg == PH_DECODE && i_insn_valid) begin
      dec_reg <= dec_now;
    end
  end

  // ----------------------------------------------------------------
  // Operand read
  // ----------------------------------------------------------------
  assign lit_form     = (dec_reg.op == OP_AND_LIT_WORK);
  // Unknown opcodes still read; nothing is written back, so it is harmless
  assign o_file_rd_en = (phase_reg == PH_READ) && !lit_form;
  assign o_file_raddr = dec_reg.addr;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      operand_reg <= 8'h00;
    end else if (phase_reg == PH_READ) begin
      // Literal bypasses the file so the read port stays idle
      if (lit_form) begin
        operand_reg <= dec_reg.literal;
      end else begin
        operand_reg <= i_file_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Process
  // ----------------------------------------------------------------
  // Widened so the carry out is dropped on purpose; carry status lives outside
  assign sum_wide = {1'h0, work_reg} + {1'h0, operand_reg};

  always_comb begin
    result_next = 8'h00;
    unique case (dec_reg.op)
      OP_ADD_WORK_FILE: begin
        result_next = sum_wide[7:0];
      end
      OP_AND_LIT_WORK: begin
        result_next = work_reg & operand_reg;
      end
      OP_AND_WORK_FILE: begin
        result_next = work_reg & operand_reg;
      end
      OP_NONE: begin
        result_next = 8'h00;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      result_reg <= 8'h00;
    end else if (phase_reg == PH_PROCESS) begin
      result_reg <= result_next;
    end
  end

  // ----------------------------------------------------------------
  // Write back
  // ----------------------------------------------------------------
  assign in_write = (phase_reg == PH_WRITE);
  assign reg_form = (dec_reg.op == OP_ADD_WORK_FILE) || (dec_reg.op == OP_AND_WORK_FILE);
  assign and_form = lit_form || (dec_reg.op == OP_AND_WORK_FILE);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      work_reg <= `WORK_RST;
    end else if (phase_reg == PH_WRITE && dec_reg.op != OP_NONE) begin
      if (dec_reg.op == OP_AND_LIT_WORK) begin
        work_reg <= result_reg;
      end else if (!dec_reg.dest_file) begin
        work_reg <= result_reg;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      file_wr_reg <= '{wr_en: 1'b0, addr: 7'h00, data: 8'h00};
    end else begin
      file_wr_reg.wr_en <= 1'b0;
      if (in_write && dec_reg.dest_file && reg_form) begin
        file_wr_reg <= '{wr_en: 1'b1, addr: dec_reg.addr, data: result_reg};
      end
    end
  end

  // ----------------------------------------------------------------
  // Zero flag
  // ----------------------------------------------------------------
  // OR chain per result bit; the flag is only ever set by hardware
  assign any_set[0] = 1'h0;
  for (genvar b = 0; b < 8; b++) begin : g_zero
    assign any_set[b + 1] = any_set[b] | result_reg[b];
  end
  assign result_is_zero = ~any_set[8];

  // Carry and digit carry of the add are handled outside this block
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      zero_reg    <= `ZERO_RST;
      zero_we_reg <= 1'h0;
    end else begin
      zero_we_reg <= 1'h0;
      if (in_write && and_form) begin
        zero_reg    <= result_is_zero;
        zero_we_reg <= 1'h1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= in_write;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_busy       = (phase_reg != PH_DECODE);
  assign o_file_wr    = file_wr_reg;
  assign o_work       = work_reg;
  assign o_zero       = zero_reg;
  assign o_zero_wr_en = zero_we_reg;
  assign o_done       = done_reg;

endmodule // byte_alu_add_and_ops

`default_nettype wire

// ==== verif/byte_alu_add_and_ops_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module byte_alu_add_and_ops_properties
  import byte_alu_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic        i_insn_valid,
  input wire logic [13:0] i_insn,
  input wire logic        o_busy,
  input wire logic        o_file_rd_en,
  input wire logic [6:0]  o_file_raddr,
  input wire file_wr_t    o_file_wr,
  input wire logic [7:0]  o_work,
  input wire logic        o_zero_wr_en,
  input wire logic        o_zero,
  input wire logic        o_done
);
  // ----------
  // Checks
  // ----------
  wire       tk = i_insn_valid & ~o_busy;
  wire [5:0] op = i_insn[13:8];
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  chk_take_done: assert property (tk |-> ##4 o_done) else $error("done late");
  chk_busy_span: assert property (tk |=> o_busy [*3] ##1 !o_busy)
    else $error("busy span wrong");
  chk_read_addr: assert property (tk && op[5:4] == 2'h0 |=>
    o_file_rd_en && o_file_raddr == $past(i_insn[6:0])) else $error("read addr");
  chk_add_no_zero: assert property (tk && op == 6'h07 |-> ##4 !o_zero_wr_en)
    else $error("add touched zero");
  chk_and_zero: assert property (tk && op inside {6'h05, 6'h39} |-> ##4 o_zero_wr_en)
    else $error("zero not updated");
  chk_zero_value: assert property (o_zero_wr_en |-> o_zero ==
    ((o_file_wr.wr_en ? o_file_wr.data : o_work) == 8'h00)) else $error("zero value");
  chk_dest_file: assert property (tk && op inside {6'h05, 6'h07} && i_insn[7] |->
    ##4 o_file_wr.wr_en && $stable(o_work) && o_file_wr.addr == $past(i_insn[6:0], 4))
    else $error("dest file");
  chk_lit_noread: assert property (tk && op == 6'h39 |=> !o_file_rd_en ##3
    !o_file_wr.wr_en) else $error("literal read");
endmodule // byte_alu_add_and_ops_properties
`default_nettype wire

// ==== verif/byte_alu_add_and_ops_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module byte_alu_add_and_ops_tb_top;
  import byte_alu_pkg::*;
  // ----------
  // Stimulus
  // ----------
  logic        clk = 0, rst_n = 0, valid = 0, busy, rd_en, zwe, zero, done;
  logic [13:0] insn = 0;
  logic [7:0]  rdata = 0, work, w_exp = 0;
  logic [6:0]  raddr;
  file_wr_t    fwr;
  logic        z_exp = 0;
  logic [5:0]  ops [4] = '{6'h07, 6'h05, 6'h39, 6'h02};
  int          failures = 0, check_count = 0, cyc = 0;
  byte_alu_add_and_ops uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_insn_valid(valid),
    .i_insn(insn), .i_file_rdata(rdata), .o_busy(busy), .o_file_rd_en(rd_en),
    .o_file_raddr(raddr), .o_file_wr(fwr), .o_work(work), .o_zero_wr_en(zwe),
    .o_zero(zero), .o_done(done));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 1500) begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("FAIL %s exp %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] res(logic [13:0] i, logic [7:0] w, logic [7:0] rd);
    return i[13:8] == 6'h07 ? w + rd : w & (i[13:8] == 6'h39 ? i[7:0] : rd);
  endfunction
  task automatic op(logic [13:0] ins, logic [7:0] rd);
    logic [7:0] r;
    logic       isand, reg_op, tofile;
    @(posedge clk);
    valid <= 1;
    insn  <= ins;
    rdata <= rd;
    @(posedge clk);
    insn <= 14'h3900; // Held valid while busy must be ignored
    @(negedge clk);
    chk("read", {busy, rd_en, raddr}, {1'b1, ins[13:12] != 2'h3, ins[6:0]});
    repeat (3) @(posedge clk);
    valid <= 0; // Dropped at the write edge so no extra instruction is taken
    r = res(ins, w_exp, rd);
    isand = ins[13:8] inside {6'h05, 6'h39};
    reg_op = ins[13:8] inside {6'h05, 6'h07};
    tofile = reg_op && ins[7];
    if ((reg_op || isand) && !tofile) w_exp = r;
    if (isand) z_exp = (r == 8'h00);
    @(negedge clk);
    chk("done", {done, busy}, 2'h2);
    chk("work", work, w_exp);
    chk("file_wr", {fwr.wr_en, tofile ? fwr[14:0] : 15'h0}, {tofile, tofile ? {ins[6:0], r} : 15'h0});
    chk("zero", {zwe, zero}, {isand, z_exp});
    $display("op %h done", ins);
  endtask
  initial begin
    void'($urandom(30));
    repeat (8) @(posedge clk);
    rst_n <= 1;
    op(14'h0704, 8'ha3);
    op(14'h395f, 8'h11);
    op(14'h05ff, 8'hc2);
    op(14'h0701, 8'hfd);
    op(14'h3900, 8'h00);
    op(14'h0280, 8'h55);
    for (int k = 0; k < 40; k++) op({ops[$urandom % 4], 8'($urandom)}, 8'($urandom));
    close_out();
  end
endmodule // byte_alu_add_and_ops_tb_top
bind byte_alu_add_and_ops byte_alu_add_and_ops_properties chk_i (.*);
`default_nettype wire
